//--- rtl/crs_regset.sv
// Purpose: programmer-visible registers, flags and stack of the cpu core
// Assumes: sequencer issues instruction strobes only while busy_o is low
// Notes:   interrupt entry and return run five-cycle stack sequences
`timescale 1ns/100ps
module crs_regset
    import crs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic        a_we_i,
    input  wire logic        x_we_i,
    input  wire logic        y_we_i,
    input  wire logic        nz_we_i,
    input  wire logic        carry_we_i,
    input  wire logic        carry_i,
    input  wire logic        add_i,
    input  wire logic        add_carry_i,
    input  wire logic [7:0]  add_op_i,
    input  wire logic        set_carry_instr_i,
    input  wire logic        reset_carry_instr_i,
    input  wire logic        set_mask_i,
    input  wire logic        clr_mask_i,
    input  wire logic        ip_lo_we_i,
    input  wire logic        ip_hi_we_i,
    input  wire logic        push_i,
    input  wire logic        push_cc_i,
    input  wire logic        pop_i,
    input  wire logic        pop_cc_i,
    input  wire logic        stack_reinit_instr_i,
    input  wire logic        sp_load_instr_i,
    input  wire logic        irq_req_i,
    input  wire logic        trap_i,
    input  wire logic        interrupt_return_instr_i,
    output logic      [7:0]  acc_o,
    output logic      [7:0]  idx_x_o,
    output logic      [7:0]  idx_y_o,
    output logic      [15:0] instruction_pointer_o,
    output logic      [7:0]  condition_flags_o,
    output logic      [15:0] stack_pointer_o,
    output logic      [7:0]  pop_data_o,
    output logic             irq_pending_o,
    output logic             int_take_o,
    output logic             busy_o
);
    typedef struct packed {
        logic [CRS_STK_DEPTH-1:0][7:0] stk;
        logic [7:0]                    a;
        logic [7:0]                    x;
        logic [7:0]                    y;
        logic [15:0]                   ip;
        logic [7:0]                    cc;
        logic [15:0]                   sp;
        logic [7:0]                    pop_q;
        logic                          pend;
        logic                          take;
        logic                          busy;
        crs_state_t                    st;
        logic [2:0]                    cnt;
    } crs_regs_t;

    crs_regs_t q_ff;
    crs_regs_t nxt_q;

    logic [7:0] sum_w;
    logic       half_w;
    logic       cout_w;
    logic [5:0] sp_dn;
    logic [5:0] sp_up;

    // low six bits move; upper ten are rebuilt from the fixed pattern
    function automatic logic [15:0] sp_fix(input logic [5:0] low);
        sp_fix = {CRS_SP_FIXED, low}; // RQ15 RQ17
    endfunction

    function automatic logic [7:0] set_nz(input logic [7:0] cc, input logic [7:0] res);
        logic [7:0] r;
        r            = cc;
        r[CRS_BIT_N] = res[7];       // RQ7
        r[CRS_BIT_Z] = (res == 8'h00); // RQ8
        set_nz = r;
    endfunction

    crs_adder u_adder (
        .op_a_i  (q_ff.a),
        .op_b_i  (add_op_i),
        .cin_i   (add_carry_i & q_ff.cc[CRS_BIT_C]),
        .sum_o   (sum_w),
        .half_o  (half_w),
        .carry_o (cout_w)
    );

    always_comb begin
        nxt_q      = q_ff;
        nxt_q.take = 1'b0;
        sp_dn      = q_ff.sp[5:0] - 6'h01; // RQ14 RQ17
        sp_up      = q_ff.sp[5:0] + 6'h01; // RQ14 RQ17
        case (q_ff.st)
            CRS_IDLE: begin
                if (a_we_i) begin
                    nxt_q.a = wr_data_i; // RQ22
                end
                if (x_we_i) begin
                    nxt_q.x = wr_data_i;
                end
                if (y_we_i) begin
                    nxt_q.y = wr_data_i;
                end
                if (nz_we_i) begin
                    nxt_q.cc = set_nz(nxt_q.cc, wr_data_i); // RQ24
                end
                if (carry_we_i) begin
                    nxt_q.cc[CRS_BIT_C] = carry_i; // RQ9 RQ10
                end
                if (add_i) begin
                    nxt_q.a             = sum_w;
                    nxt_q.cc            = set_nz(nxt_q.cc, sum_w); // RQ24
                    nxt_q.cc[CRS_BIT_H] = half_w;                  // RQ1
                    nxt_q.cc[CRS_BIT_C] = cout_w;                  // RQ9
                end
                if (set_carry_instr_i) begin
                    nxt_q.cc[CRS_BIT_C] = 1'b1; // RQ10
                end
                if (reset_carry_instr_i) begin
                    nxt_q.cc[CRS_BIT_C] = 1'b0; // RQ10
                end
                if (set_mask_i) begin
                    nxt_q.cc[CRS_BIT_I] = 1'b1; // RQ2
                end
                if (clr_mask_i) begin
                    nxt_q.cc[CRS_BIT_I] = 1'b0;
                end
                if (ip_lo_we_i) begin
                    nxt_q.ip[7:0] = wr_data_i; // RQ13
                end
                if (ip_hi_we_i) begin
                    nxt_q.ip[15:8] = wr_data_i; // RQ13
                end
                if (push_i || push_cc_i) begin
                    nxt_q.stk[q_ff.sp[5:0]] = push_cc_i ? q_ff.cc : wr_data_i; // RQ14 RQ21
                    nxt_q.sp                = sp_fix(sp_dn);
                end else if (pop_i || pop_cc_i) begin
                    nxt_q.sp = sp_fix(sp_up); // RQ14
                    if (pop_cc_i) begin
                        nxt_q.cc = q_ff.stk[sp_up] | CRS_CC_ONES; // RQ21
                    end else begin
                        nxt_q.pop_q = q_ff.stk[sp_up];
                    end
                end
                if (sp_load_instr_i) begin
                    nxt_q.sp = sp_fix(wr_data_i[5:0]); // RQ20
                end
                if (stack_reinit_instr_i) begin
                    nxt_q.sp = sp_fix(CRS_SP_LOW_RST); // RQ16
                end
                if (interrupt_return_instr_i) begin
                    nxt_q.st   = CRS_POP;
                    nxt_q.cnt  = 3'h0;
                    nxt_q.busy = 1'b1;
                end else if (trap_i || (q_ff.pend && !q_ff.cc[CRS_BIT_I])) begin // RQ3 RQ6
                    nxt_q.st   = CRS_PUSH;
                    nxt_q.cnt  = 3'h0;
                    nxt_q.busy = 1'b1;
                    nxt_q.take = 1'b1;
                    if (!trap_i) begin
                        nxt_q.pend = 1'b0; // RQ4
                    end
                end
            end
            CRS_PUSH: begin
                // context order: ipl, iph, x, a, flags; y stays out
                case (q_ff.cnt)
                    3'h0:    nxt_q.stk[q_ff.sp[5:0]] = q_ff.ip[7:0];  // RQ18
                    3'h1:    nxt_q.stk[q_ff.sp[5:0]] = q_ff.ip[15:8]; // RQ23
                    3'h2:    nxt_q.stk[q_ff.sp[5:0]] = q_ff.x;        // RQ12
                    3'h3:    nxt_q.stk[q_ff.sp[5:0]] = q_ff.a;
                    default: nxt_q.stk[q_ff.sp[5:0]] = q_ff.cc;
                endcase
                nxt_q.sp  = sp_fix(sp_dn);
                nxt_q.cnt = q_ff.cnt + 3'h1;
                if (q_ff.cnt == CRS_CTX_LAST) begin // RQ19
                    nxt_q.cc[CRS_BIT_I] = 1'b1; // RQ2
                    nxt_q.st            = CRS_IDLE;
                    nxt_q.busy          = 1'b0;
                end
            end
            CRS_POP: begin
                case (q_ff.cnt)
                    3'h0:    nxt_q.cc       = q_ff.stk[sp_up] | CRS_CC_ONES; // RQ5
                    3'h1:    nxt_q.a        = q_ff.stk[sp_up];               // RQ23
                    3'h2:    nxt_q.x        = q_ff.stk[sp_up];
                    3'h3:    nxt_q.ip[15:8] = q_ff.stk[sp_up];
                    default: nxt_q.ip[7:0]  = q_ff.stk[sp_up];
                endcase
                nxt_q.sp  = sp_fix(sp_up);
                nxt_q.cnt = q_ff.cnt + 3'h1;
                if (q_ff.cnt == CRS_CTX_LAST) begin // RQ19
                    nxt_q.st   = CRS_IDLE;
                    nxt_q.busy = 1'b0;
                end
            end
            default: begin
                nxt_q.st   = CRS_IDLE;
                nxt_q.busy = 1'b0;
            end
        endcase
        // a new request wins over the clear made when it is taken
        if (irq_req_i) begin
            nxt_q.pend = 1'b1; // RQ4
        end
        nxt_q.cc = nxt_q.cc | CRS_CC_ONES; // RQ11
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q_ff      <= '0;
            q_ff.cc   <= CRS_CC_RESET; // RQ11
            q_ff.sp   <= CRS_SP_RESET; // RQ15 RQ16
            q_ff.st   <= CRS_IDLE;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign acc_o                 = q_ff.a;
    assign idx_x_o               = q_ff.x;
    assign idx_y_o               = q_ff.y;
    assign instruction_pointer_o = q_ff.ip;
    assign condition_flags_o     = q_ff.cc;
    assign stack_pointer_o       = q_ff.sp;
    assign pop_data_o            = q_ff.pop_q;
    assign irq_pending_o         = q_ff.pend;
    assign int_take_o            = q_ff.take;
    assign busy_o                = q_ff.busy;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    logic idle_w;
    assign idle_w = (q_ff.st == CRS_IDLE);

    chk_half_add: assert property ( // RQ1
        idle_w && add_i && !interrupt_return_instr_i
        |=> condition_flags_o[CRS_BIT_H] == $past(half_w))
        else $error("half-carry not taken from the adder");

    chk_mask_entry: assert property ( // RQ2
        int_take_o |-> ##5 condition_flags_o[CRS_BIT_I])
        else $error("mask not set after interrupt entry");

    chk_mask_block: assert property ( // RQ3
        idle_w && !trap_i && condition_flags_o[CRS_BIT_I] && !interrupt_return_instr_i
        |=> !int_take_o)
        else $error("maskable interrupt taken while masked");

    chk_pend_serve: assert property ( // RQ4
        idle_w && irq_pending_o && !condition_flags_o[CRS_BIT_I]
        && !interrupt_return_instr_i |=> int_take_o)
        else $error("pending interrupt not served once unmasked");

    chk_ctx_five: assert property ( // RQ19
        int_take_o |-> busy_o [*5] ##1 !busy_o)
        else $error("interrupt context is not five bytes");

    chk_ctx_sp: assert property ( // RQ19
        int_take_o |-> ##5 stack_pointer_o[5:0] == $past(stack_pointer_o[5:0], 5) - 6'h05)
        else $error("interrupt entry moved pointer wrongly");

    chk_sp_fixed: assert property ( // RQ15
        stack_pointer_o[15:6] == CRS_SP_FIXED)
        else $error("upper stack pointer bits changed");

    chk_sp_reinit: assert property ( // RQ16
        idle_w && stack_reinit_instr_i |=> stack_pointer_o == CRS_SP_RESET)
        else $error("stack reinit did not restore pointer");

    chk_push_wrap: assert property ( // RQ17
        idle_w && push_i && !sp_load_instr_i && !stack_reinit_instr_i
        && stack_pointer_o[5:0] == 6'h00 |=> stack_pointer_o[5:0] == 6'h3f)
        else $error("push below the stack did not wrap");

    chk_zero_flag: assert property ( // RQ8
        idle_w && nz_we_i && !add_i |=> condition_flags_o[CRS_BIT_Z] == ($past(wr_data_i) == 8'h00))
        else $error("zero flag wrong after data move");

    cov_entry: cover property (int_take_o ##5 idle_w);
    cov_return: cover property (idle_w && interrupt_return_instr_i ##6 idle_w);
    cov_pend_masked: cover property (irq_pending_o && condition_flags_o[CRS_BIT_I]);
    cov_wrap: cover property (stack_pointer_o[5:0] == 6'h00 ##1 stack_pointer_o[5:0] == 6'h3f);
endmodule

//--- rtl/crs_pkg.sv
// Purpose: shared constants and types of the cpu core register set
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes:   stack holds 64 bytes; the upper ten pointer bits are fixed
// Contract
// RQ1: add sets half-carry on bit3 carry
// RQ2: interrupt entry sets the mask flag
// RQ3: mask blocks maskable interrupts, not trap
// RQ4: masked requests stay pending until unmasked
// RQ5: interrupt return restores context, clearing mask
// RQ6: unmasked pending served regardless of priority
// RQ7: sign flag copies result bit seven
// RQ8: zero flag set on zero result
// RQ9: carry flag shows overflow or borrow
// RQ10: set/reset carry; shifts and tests update carry
// RQ11: reset loads condition flags 111x1xxx
// RQ12: second index register never joins context
// RQ13: sixteen-bit pointer with separate byte halves
// RQ14: push then decrement, increment then pop
// RQ15: 64-byte stack, fixed upper bits, reset 00ff
// RQ16: reset or reinit sets low six bits
// RQ17: stack pointer wraps silently both ways
// RQ18: context push starts with pointer low byte
// RQ19: call uses two bytes, interrupt five
// RQ20: stack pointer low byte loadable and readable
// RQ21: condition flags pushable and poppable
// RQ22: accumulator and index registers are eight bits
// RQ23: context order ipl, iph, x, a, flags
// RQ24: flags update with the result write
package crs_pkg;
    localparam int          CRS_STK_DEPTH = 64;
    localparam int          CRS_SP_BITS   = 6;
    localparam int          CRS_CTX_BYTES = 5;
    localparam int          CRS_CALL_BYTES = 2;
    localparam logic [7:0]  CRS_CC_RESET  = 8'he8;
    localparam logic [15:0] CRS_SP_RESET  = 16'h00ff;
    localparam logic [9:0]  CRS_SP_FIXED  = 10'h003;
    localparam logic [5:0]  CRS_SP_LOW_RST = 6'h3f;
    localparam logic [2:0]  CRS_CTX_LAST  = 3'h4;
    localparam int          CRS_BIT_H     = 4;
    localparam int          CRS_BIT_I     = 3;
    localparam int          CRS_BIT_N     = 2;
    localparam int          CRS_BIT_Z     = 1;
    localparam int          CRS_BIT_C     = 0;
    localparam logic [7:0]  CRS_CC_ONES   = 8'he0;

    typedef enum logic [1:0] {
        CRS_IDLE,
        CRS_PUSH,
        CRS_POP
    } crs_state_t;
endpackage

//--- rtl/crs_adder.sv
// Purpose: eight-bit adder giving sum, half-carry and carry
// Assumes: purely combinational, used by the register set
// Notes:   half-carry is the carry out of the low nibble
`timescale 1ns/100ps
module crs_adder (
    input  wire logic [7:0] op_a_i,
    input  wire logic [7:0] op_b_i,
    input  wire logic       cin_i,
    output logic      [7:0] sum_o,
    output logic            half_o,
    output logic            carry_o
);
    logic [4:0] lo;
    logic [4:0] hi;

    always_comb begin
        lo      = {1'b0, op_a_i[3:0]} + {1'b0, op_b_i[3:0]} + {4'h0, cin_i};
        hi      = {1'b0, op_a_i[7:4]} + {1'b0, op_b_i[7:4]} + {4'h0, lo[4]};
        sum_o   = {hi[3:0], lo[3:0]};
        half_o  = lo[4]; // RQ1
        carry_o = hi[4]; // RQ9
    end
endmodule

//--- testbench/crs_seq_model.sv
// Purpose: sequencer-side stand-in raising interrupt requests and returns
// Assumes: one clock shared with the register set
// Notes:   LAG delays each request to mimic a slow interrupt source
`timescale 1ns/100ps
module crs_seq_model #(
    parameter int LAG = 2
) (
    input  wire logic clk_i,
    input  wire logic busy_i,
    input  wire logic irq_cmd_i,
    input  wire logic ret_cmd_i,
    output logic      irq_req_o,
    output logic      ret_o
);
    logic [LAG-1:0] dly_ff = '0;
    initial irq_req_o = 1'b0;
    initial ret_o = 1'b0;
    always @(posedge clk_i) begin
        dly_ff <= {dly_ff[LAG-2:0], irq_cmd_i};
        irq_req_o <= dly_ff[LAG-1];
        // return strobe only offered while the register set is idle
        ret_o <= ret_cmd_i & ~busy_i;
    end
endmodule

//--- testbench/testbench.sv
// Purpose: self-checking bench for the cpu core register set
// Assumes: strobes are one-cycle pulses issued while busy_o is low
// Notes:   expected values are worked out by hand from the flag layout
`timescale 1ns/100ps
module testbench;
    import crs_pkg::*;
    localparam int S_A = 0, S_X = 1, S_Y = 2, S_NZ = 3, S_CWE = 4, S_ADD = 5, S_SCF = 6;
    localparam int S_RCF = 7, S_SETM = 8, S_CLRM = 9, S_IPL = 10, S_IPH = 11, S_PUSH = 12;
    localparam int S_PCC = 13, S_POP = 14, S_POPCC = 15, S_RSP = 16, S_SPLD = 17, S_TRAP = 18;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [7:0]  wr_data_i = '0;
    logic [7:0]  add_op_i = '0;
    logic        carry_i = 1'b0;
    logic        add_carry_i = 1'b0;
    logic [18:0] stb = '0;
    logic        irq_cmd = 1'b0;
    logic        ret_cmd = 1'b0;
    logic        irq_req, interrupt_return_instr, irq_pending_o, int_take_o, busy_o;
    logic [7:0]  acc_o, idx_x_o, idx_y_o, condition_flags_o, pop_data_o;
    logic [15:0] instruction_pointer_o, stack_pointer_o;
    int          n_mismatch = 0;
    int          total_checks = 0;
    always #5 clk_i = ~clk_i;
    crs_seq_model #(.LAG(2)) seq (.clk_i(clk_i), .busy_i(busy_o), .irq_cmd_i(irq_cmd),
        .ret_cmd_i(ret_cmd), .irq_req_o(irq_req), .ret_o(interrupt_return_instr));
    crs_regset dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wr_data_i(wr_data_i),
        .a_we_i(stb[S_A]), .x_we_i(stb[S_X]), .y_we_i(stb[S_Y]), .nz_we_i(stb[S_NZ]),
        .carry_we_i(stb[S_CWE]), .carry_i(carry_i), .add_i(stb[S_ADD]),
        .add_carry_i(add_carry_i), .add_op_i(add_op_i), .set_carry_instr_i(stb[S_SCF]),
        .reset_carry_instr_i(stb[S_RCF]), .set_mask_i(stb[S_SETM]), .clr_mask_i(stb[S_CLRM]),
        .ip_lo_we_i(stb[S_IPL]), .ip_hi_we_i(stb[S_IPH]), .push_i(stb[S_PUSH]),
        .push_cc_i(stb[S_PCC]), .pop_i(stb[S_POP]), .pop_cc_i(stb[S_POPCC]),
        .stack_reinit_instr_i(stb[S_RSP]), .sp_load_instr_i(stb[S_SPLD]),
        .irq_req_i(irq_req), .trap_i(stb[S_TRAP]), .interrupt_return_instr_i(interrupt_return_instr),
        .acc_o(acc_o), .idx_x_o(idx_x_o), .idx_y_o(idx_y_o),
        .instruction_pointer_o(instruction_pointer_o), .condition_flags_o(condition_flags_o),
        .stack_pointer_o(stack_pointer_o), .pop_data_o(pop_data_o),
        .irq_pending_o(irq_pending_o), .int_take_o(int_take_o), .busy_o(busy_o));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic op(input int i, input logic [7:0] d, input logic c);
        @(posedge clk_i);
        stb[i] <= 1'b1;
        wr_data_i <= d;
        add_op_i <= d;
        carry_i <= c;
        add_carry_i <= c;
        @(posedge clk_i);
        stb <= '0;
        #1;
    endtask

    // polls for the take pulse or for the end of a stack sequence
    task automatic wait_for(input bit take);
        int n;
        n = 0;
        while ((take ? int_take_o : ~busy_o) !== 1'b1 && n < 30) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        // a poll that runs out counts against the run
        if (n >= 30) begin
            n_mismatch++;
        end
    endtask

    task automatic t_reset();
        chk(condition_flags_o, 16'h00e8);
        chk(stack_pointer_o, 16'h00ff);
        chk(acc_o, 16'h0000);
    endtask

    task automatic t_alu();
        op(S_A, 8'h01, 1'b0);
        op(S_ADD, 8'h0f, 1'b0);
        chk(acc_o, 16'h0010);
        chk(condition_flags_o, 16'h00f8);
        op(S_ADD, 8'hff, 1'b0);
        chk({acc_o, condition_flags_o}, 16'h0fe9);
        op(S_ADD, 8'hf0, 1'b1);
        chk({acc_o, condition_flags_o}, 16'h00fb);
        op(S_NZ, 8'h80, 1'b0);
        chk(condition_flags_o, 16'h00fd);
        op(S_RCF, 8'h00, 1'b0);
        chk(condition_flags_o, 16'h00fc);
        op(S_SCF, 8'h00, 1'b0);
        chk(condition_flags_o, 16'h00fd);
        op(S_CWE, 8'h00, 1'b0);
        chk(condition_flags_o, 16'h00fc);
    endtask

    task automatic t_stack();
        op(S_SPLD, 8'h00, 1'b0);
        chk(stack_pointer_o, 16'h00c0);
        op(S_PUSH, 8'h5a, 1'b0);
        chk(stack_pointer_o, 16'h00ff);
        op(S_POP, 8'h00, 1'b0);
        chk({pop_data_o, stack_pointer_o[7:0]}, 16'h5ac0);
        op(S_PCC, 8'h00, 1'b0);
        op(S_SCF, 8'h00, 1'b0);
        op(S_POPCC, 8'h00, 1'b0);
        chk(condition_flags_o, 16'h00fc);
        op(S_RSP, 8'h00, 1'b0);
        chk(stack_pointer_o, 16'h00ff);
    endtask

    task automatic t_irq();
        op(S_A, 8'h33, 1'b0);
        op(S_X, 8'h11, 1'b0);
        op(S_IPL, 8'h44, 1'b0);
        op(S_IPH, 8'h55, 1'b0);
        @(posedge clk_i);
        irq_cmd <= 1'b1;
        @(posedge clk_i);
        irq_cmd <= 1'b0;
        repeat (10) @(posedge clk_i);
        #1;
        chk({irq_pending_o, int_take_o, busy_o}, 16'h0004);
        op(S_CLRM, 8'h00, 1'b0);
        wait_for(1'b1);
        chk(int_take_o, 16'h0001);
        wait_for(1'b0);
        chk({stack_pointer_o[7:0], condition_flags_o}, 16'hfafc);
        chk(irq_pending_o, 16'h0000);
        op(S_A, 8'h00, 1'b0);
        op(S_X, 8'h00, 1'b0);
        op(S_Y, 8'h66, 1'b0);
        @(posedge clk_i);
        ret_cmd <= 1'b1;
        @(posedge clk_i);
        ret_cmd <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        wait_for(1'b0);
        chk({acc_o, idx_x_o}, 16'h3311);
        chk(idx_y_o, 16'h0066);
        chk(instruction_pointer_o, 16'h5544);
        chk(condition_flags_o, 16'h00f4);
        chk(stack_pointer_o, 16'h00ff);
    endtask

    task automatic t_trap();
        logic [7:0] ctx [5];
        ctx = '{8'hfc, 8'h33, 8'h11, 8'h55, 8'h44};
        op(S_SETM, 8'h00, 1'b0);
        op(S_TRAP, 8'h00, 1'b0);
        wait_for(1'b1);
        chk(int_take_o, 16'h0001);
        wait_for(1'b0);
        chk(stack_pointer_o, 16'h00fa);
        foreach (ctx[k]) begin
            op(S_POP, 8'h00, 1'b0);
            chk(pop_data_o, {8'h00, ctx[k]});
        end
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #100us;
        n_mismatch++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        t_reset();
        t_alu();
        t_stack();
        t_irq();
        t_trap();
        close_out();
    end
endmodule
